// File: shared/pic_pkg.sv
/*
 * Shared definitions of the prioritized interrupt controller: register offsets,
 * control field positions, reset values, edge codes and the request carrier.
 * Assumes a 32-bit AXI4-Lite register bus and one CPU core taking requests.
 */
package pic_pkg;

   localparam int PIC_NUM_SRC = 16;
   localparam int PIC_NUM_PIN = 16;
   localparam int PIC_LVL_W = 2;
   localparam int PIC_IDX_W = 4;
   localparam int PIC_SYNC_STAGES = 3;

   // Source slots of the two external units
   localparam logic [3:0] PIC_SRC_EXT_A = 4'h1;
   localparam logic [3:0] PIC_SRC_EXT_B = 4'h2;

   // Register byte offsets
   localparam logic [7:0] PIC_OFF_CTRL = 8'h00;
   localparam logic [7:0] PIC_OFF_ENABLE = 8'h04;
   localparam logic [7:0] PIC_OFF_PRIORITY = 8'h08;
   localparam logic [7:0] PIC_OFF_FLAGS = 8'h0C;
   localparam logic [7:0] PIC_OFF_PIN_FLAGS = 8'h10;
   localparam logic [7:0] PIC_OFF_PIN_ENABLES = 8'h14;
   localparam logic [7:0] PIC_OFF_STATUS = 8'h18;

   // Control register field positions
   localparam int PIC_CTRL_GIE = 0;
   localparam int PIC_CTRL_A_EN = 1;
   localparam int PIC_CTRL_B_EN = 2;
   localparam int PIC_CTRL_A_SEL = 3;
   localparam int PIC_CTRL_A_EDGE = 6;
   localparam int PIC_CTRL_B_EDGE = 8;
   localparam int PIC_CTRL_W = 10;

   // Status register field positions
   localparam int PIC_STAT_REQ = 4;
   localparam int PIC_STAT_IDX = 8;
   localparam int PIC_STAT_LVL = 12;

   // Reset values
   localparam logic [31:0] PIC_RST_WORD = 32'h0000_0000;

   // Edge select codes
   localparam logic [1:0] PIC_EDGE_RISE = 2'h0;
   localparam logic [1:0] PIC_EDGE_FALL = 2'h1;
   localparam logic [1:0] PIC_EDGE_BOTH = 2'h2;

   // AXI responses
   localparam logic [1:0] PIC_RESP_OKAY = 2'h0;
   localparam logic [1:0] PIC_RESP_SLVERR = 2'h2;

   // Request offered to the CPU core
   typedef struct packed {
      logic valid;
      logic [3:0] source;
      logic [1:0] level;
   } pic_req_t;

endpackage : pic_pkg

// File: src/pic_top.sv
/*
 * Prioritized interrupt controller: 16 sources with flags, enables, four
 * priority levels, nesting, and two edge-triggered external units.
 * Assumes internal peripherals pulse src_event, pins are asynchronous,
 * and the CPU pulses irq_ack on entry and irq_done on routine return.
 */
// Behaviour
// - Sixteen sources, each with two-bit level
// - Hardware sets flag on source condition
// - Request needs global, own enable, flag
// - Serve only if no higher service active
// - Higher preempts lower; lower resumes afterwards
// - Equal level never preempts routine in service
// - Larger level wins, levels reset zero
// - Higher level first, lower index breaks ties
// - Reset outranks all, no level field
// - Global enable low blocks every request
// - Masked flags stay pending, fire on enable
// - External units: rise, fall, or both
// - Unit A: selectable trigger, one flag
// - Unit B: sixteen pins, own flags, enables
// - Unit B edge and level own fields
// - Flags clear by writing zero only
`timescale 1ns/1ps
module pic_top
   import pic_pkg::*;
#(
   parameter int NUM_A_INPUTS = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [PIC_NUM_SRC-1:0] src_event,
   input wire logic [NUM_A_INPUTS-1:0] ext_irq_a_pins,
   input wire logic [PIC_NUM_PIN-1:0] ext_irq_b_pins,
   output pic_req_t irq_req,
   input wire logic irq_ack,
   input wire logic irq_done
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [PIC_CTRL_W-1:0] ctrl;
   logic [PIC_NUM_SRC-1:0] src_enable, flags, pending, set_flags, clr_mask;
   logic [2*PIC_NUM_SRC-1:0] priority_cfg;
   logic [PIC_NUM_PIN-1:0] pin_flags, pin_enables, b_s1, b_s2, b_s3, b_lvl, next_b_lvl, b_edge;
   logic [NUM_A_INPUTS-1:0] a_s1, a_s2, a_s3, a_lvl, next_a_lvl;
   logic [3:0] in_service, w_strb, win_idx;
   logic [1:0] win_lvl, active_lvl;
   logic [7:0] aw_addr;
   logic [31:0] w_data, wmask;
   logic aw_full, w_full, aw_high, wr_fire, wr_en, wr_hit, win_found, a_edge, allowed;

   ////////////////////////////////////////////////////////////////////////////
   // Edge test on a filtered level, shared by both units
   function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
      case (sel)
         PIC_EDGE_RISE: edge_hit = !prev && cur;
         PIC_EDGE_FALL: edge_hit = prev && !cur;
         PIC_EDGE_BOTH: edge_hit = prev != cur;
         default: edge_hit = 1'b0;
      endcase
   endfunction : edge_hit

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the filtered level moves only when stages two and three agree
   // three-stage pin capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_s1 <= '0;
         a_s2 <= '0;
         a_s3 <= '0;
         b_s1 <= '0;
         b_s2 <= '0;
         b_s3 <= '0;
      end else begin
         a_s1 <= ext_irq_a_pins;
         a_s2 <= a_s1;
         a_s3 <= a_s2;
         b_s1 <= ext_irq_b_pins;
         b_s2 <= b_s1;
         b_s3 <= b_s2;
      end
   end

   // Agreement filter rejects a one-cycle disagreement between late stages
   always_comb begin
      next_a_lvl = a_lvl;
      next_b_lvl = b_lvl;
      for (int i = 0; i < NUM_A_INPUTS; i++) begin
         if (a_s2[i] == a_s3[i]) next_a_lvl[i] = a_s3[i];
      end
      for (int i = 0; i < PIC_NUM_PIN; i++) begin
         if (b_s2[i] == b_s3[i]) next_b_lvl[i] = b_s3[i];
      end
   end

   // Filtered levels, reset low so a pin held high after reset gives a rising edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_lvl <= '0;
         b_lvl <= '0;
      end else begin
         a_lvl <= next_a_lvl;
         b_lvl <= next_b_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection per unit
   always_comb begin
      logic [2:0] sel;
      sel = ctrl[PIC_CTRL_A_SEL +: 3];
      // one selected trigger feeds unit A
      a_edge = edge_hit(ctrl[PIC_CTRL_A_EDGE +: 2], a_lvl[sel], next_a_lvl[sel]);
      // unit B uses its own edge field
      for (int i = 0; i < PIC_NUM_PIN; i++) begin
         b_edge[i] = edge_hit(ctrl[PIC_CTRL_B_EDGE +: 2], b_lvl[i], next_b_lvl[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel: address and data accepted in either order
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign wr_fire = aw_full && w_full && !s_axi_bvalid;
   assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   // Out-of-range addresses are answered but must not touch any register
   assign wr_en = wr_fire && !aw_high;
   assign clr_mask = wr_en ? 16'(~w_data & wmask) : 16'h0000;

   always_comb begin
      case (aw_addr)
         PIC_OFF_CTRL, PIC_OFF_ENABLE, PIC_OFF_PRIORITY, PIC_OFF_FLAGS, PIC_OFF_PIN_FLAGS,
         PIC_OFF_PIN_ENABLES, PIC_OFF_STATUS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= '0;
         aw_high <= 1'b0;
         w_data <= PIC_RST_WORD;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PIC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr[7:0];
            aw_high <= |s_axi_awaddr[31:8];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_hit && !aw_high) ? PIC_RESP_OKAY : PIC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Plain read/write configuration registers
   // levels reset to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= '0;
         src_enable <= '0;
         priority_cfg <= '0;
         pin_enables <= '0;
      end else if (wr_en) begin
         case (aw_addr)
            PIC_OFF_CTRL: ctrl <= PIC_CTRL_W'((ctrl & ~wmask[PIC_CTRL_W-1:0]) | (w_data & wmask));
            PIC_OFF_ENABLE: src_enable <= 16'((src_enable & ~wmask[15:0]) | (w_data & wmask));
            PIC_OFF_PRIORITY: priority_cfg <= (priority_cfg & ~wmask) | (w_data & wmask);
            PIC_OFF_PIN_ENABLES: pin_enables <= 16'((pin_enables & ~wmask[15:0]) | (w_data & wmask));
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags: hardware sets, software clears by writing zero; a set wins a clear
   always_comb begin
      set_flags = src_event;
      set_flags[PIC_SRC_EXT_A] = a_edge;
      set_flags[PIC_SRC_EXT_B] = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= '0;
         pin_flags <= '0;
      end else begin
         // writing one leaves a flag alone
         flags <= (flags & ~(aw_addr == PIC_OFF_FLAGS ? clr_mask : 16'h0000)) | set_flags;
         pin_flags <= (pin_flags & ~(aw_addr == PIC_OFF_PIN_FLAGS ? clr_mask : 16'h0000)) | b_edge;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pending sources; masked flags stay set and fire once unmasked
   always_comb begin
      pending = flags & src_enable;
      pending[PIC_SRC_EXT_A] = flags[PIC_SRC_EXT_A] && ctrl[PIC_CTRL_A_EN];
      // group enable gates the pin set
      pending[PIC_SRC_EXT_B] = ctrl[PIC_CTRL_B_EN] && |(pin_flags & pin_enables);
   end

   // Arbitration: walk down from the top index so ties settle on the lower one
   always_comb begin
      win_found = 1'b0;
      win_idx = '0;
      win_lvl = '0;
      for (int i = PIC_NUM_SRC - 1; i >= 0; i--) begin
         if (pending[i] && (!win_found || priority_cfg[2*i +: 2] >= win_lvl)) begin
            win_found = 1'b1;
            win_idx = 4'(i);
            win_lvl = priority_cfg[2*i +: 2];
         end
      end
   end

   // Highest level now in service
   always_comb begin
      active_lvl = '0;
      for (int l = 0; l < 4; l++) begin
         if (in_service[l]) active_lvl = 2'(l);
      end
      allowed = win_found && ctrl[PIC_CTRL_GIE] && (in_service == '0 || win_lvl > active_lvl);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request to the CPU, registered so source and level are stable together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_req <= '0;
      end else begin
         irq_req.valid <= allowed && !irq_ack;
         irq_req.source <= win_idx;
         irq_req.level <= win_lvl;
      end
   end

   // In-service stack; reset clears it, so reset outranks any routine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_service <= '0;
      end else if (irq_ack && irq_req.valid) begin
         in_service[irq_req.level] <= 1'b1;
      end else if (irq_done) begin
         in_service[active_lvl] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= PIC_RST_WORD;
         s_axi_rresp <= PIC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= PIC_RESP_OKAY;
         s_axi_rdata <= PIC_RST_WORD;
         if (s_axi_araddr[31:8] != '0) begin
            s_axi_rresp <= PIC_RESP_SLVERR;
         end else begin
            case (s_axi_araddr[7:0])
               PIC_OFF_CTRL: s_axi_rdata <= 32'(ctrl);
               PIC_OFF_ENABLE: s_axi_rdata <= 32'(src_enable);
               PIC_OFF_PRIORITY: s_axi_rdata <= priority_cfg;
               PIC_OFF_FLAGS: s_axi_rdata <= 32'(flags | (16'(|pin_flags) << PIC_SRC_EXT_B));
               PIC_OFF_PIN_FLAGS: s_axi_rdata <= 32'(pin_flags);
               PIC_OFF_PIN_ENABLES: s_axi_rdata <= 32'(pin_enables);
               PIC_OFF_STATUS: begin
                  s_axi_rdata[3:0] <= in_service;
                  s_axi_rdata[PIC_STAT_REQ] <= irq_req.valid;
                  s_axi_rdata[PIC_STAT_IDX +: 4] <= irq_req.source;
                  s_axi_rdata[PIC_STAT_LVL +: 2] <= irq_req.level;
               end
               default: s_axi_rresp <= PIC_RESP_SLVERR;
            endcase
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : pic_top

// File: sim/pic_asserts.sv
/* Port checker of the interrupt controller.
   Bound into pic_top; sees only its ports. */
`timescale 1ns/1ps
module pic_asserts
   import pic_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire pic_req_t irq_req,
   input wire logic irq_ack,
   input wire logic irq_done
);
   logic [3:0] svc;
   logic [1:0] top;
   logic [2:0] off;
   logic wr_go;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   // Highest level in service, and a write taken whole
   assign top = svc[3] ? 2'h3 : (svc[2] ? 2'h2 : {1'b0, svc[1]});
   assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // Levels entered by the core; a return retires only the highest
   always_ff @(posedge aclk) begin
      if (!aresetn) svc <= 4'h0;
      else if (irq_ack && irq_req.valid) svc[irq_req.level] <= 1'b1;
      else if (irq_done) svc[top] <= 1'b0;
   end
   // Age of a low global enable; the slack covers write and request lag
   always_ff @(posedge aclk) begin
      if (!aresetn) off <= 3'h7;
      else if (wr_go && s_axi_awaddr[7:0] == PIC_OFF_CTRL) off <= {2'h0, !s_axi_wdata[PIC_CTRL_GIE]};
      else if (off != 3'h0 && off != 3'h7) off <= off + 3'h1;
   end
   ////////////////////////////////////////
   a_nest_level: assert property (irq_req.valid && svc != 4'h0 |-> irq_req.level > top)
      else $error("request not above level in service");
   a_gie_blocks: assert property (off > 3'h3 |-> !irq_req.valid)
      else $error("request while global enable low");
   a_ack_drops: assert property (irq_req.valid && irq_ack |=> !irq_req.valid)
      else $error("request held after entry");
   a_write_answer: assert property (wr_go |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   a_b_holds: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
      else $error("write answer dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_r_holds: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
      else $error("read answer dropped early");
   a_busy_refuse: assert property (s_axi_bvalid || s_axi_rvalid |-> !(s_axi_bvalid && s_axi_awready))
      else $error("write taken while answer pending");
endmodule : pic_asserts
bind pic_top pic_asserts chk (.*);

// File: sim/pic_cpu_model.sv
/* Core model: enters a standing request and returns on command.
   Assumes the bench paces entries with ack_en and returns with done_cmd. */
`timescale 1ns/1ps
module pic_cpu_model
   import pic_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire pic_req_t irq_req,
   input wire logic ack_en,
   input wire logic done_cmd,
   output logic irq_ack,
   output logic irq_done
);
   ////////////////////////////////////////
   // nested entry
   // One-cycle entry pulse; ack_en low lets a request wait unserved
   always_ff @(posedge aclk) begin
      if (!aresetn) irq_ack <= 1'b0;
      else irq_ack <= ack_en && irq_req.valid && !irq_ack;
   end
   // routine return
   // Return pulse one cycle after the command
   always_ff @(posedge aclk) begin
      irq_done <= aresetn && done_cmd;
   end
endmodule : pic_cpu_model

// File: sim/tb.sv
/* Bench of the interrupt controller with a core model.
   Drives AXI4-Lite, events and pins at rising aclk. */
`timescale 1ns/1ps
`define CHK(a,e) begin cmp_count++; if ((a)!==(e)) begin num_errors++; $display("[ERR] %0t %0h %0h",$time,a,e); end end
module tb
   import pic_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, ack_en = 1'b0, done_cmd = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic irq_ack, irq_done;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
   logic [15:0] src_event = '0, ext_irq_b_pins = '0;
   logic [7:0] ext_irq_a_pins = '0;
   pic_req_t irq_req;
   int num_errors = 0, cmp_count = 0;
   // Clock and the parts under test
   always #2 aclk = ~aclk;
   pic_top dut (.*);
   pic_cpu_model cpu (.*);
   ////////////////////////////////////////
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic oa, ow, b;
      @(posedge aclk);
      s_axi_awaddr <= {24'h00_0000, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         oa = s_axi_awvalid && s_axi_awready;
         ow = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge aclk);
         if (oa) s_axi_awvalid <= 1'b0;
         if (ow) s_axi_wvalid <= 1'b0;
      end while (!b);
      s_axi_bready <= 1'b0;
   endtask : wr
   // Read: data and response sampled at the falling aclk edge that sees rvalid high
   task automatic rd(input logic [7:0] a);
      logic oa, r;
      @(posedge aclk);
      s_axi_araddr <= {24'h00_0000, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         oa = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         rv = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge aclk);
         if (oa) s_axi_arvalid <= 1'b0;
      end while (!r);
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic fire(input logic [15:0] m);
      @(posedge aclk);
      src_event <= m;
      @(posedge aclk);
      src_event <= 16'h0000;
   endtask : fire
   task automatic wait_req(input pic_req_t e);
      int n;
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (irq_req.valid !== 1'b1 && n < 40);
      `CHK(irq_req, e)
   endtask : wait_req
   // Settling margin first, so a request being withdrawn is not miscounted
   task automatic quiet();
      logic seen;
      seen = 1'b0;
      repeat (4) @(posedge aclk);
      repeat (8) begin
         @(negedge aclk);
         seen |= irq_req.valid;
      end
      `CHK(seen, 1'b0)
   endtask : quiet
   task automatic ret();
      @(posedge aclk);
      done_cmd <= 1'b1;
      @(posedge aclk);
      done_cmd <= 1'b0;
   endtask : ret
   task automatic pin_a(input logic [7:0] v, input logic x);
      wr(PIC_OFF_FLAGS, 32'h0000_0000);
      ext_irq_a_pins <= v;
      repeat (8) @(posedge aclk);
      rd(PIC_OFF_FLAGS);
      `CHK(rv[1], x)
   endtask : pin_a
   ////////////////////////////////////////
   task automatic t_reset();
      for (int i = 0; i < 7; i++) begin
         rd(8'(i * 4));
         `CHK(rv, PIC_RST_WORD)
      end
      rd(8'h20);
      `CHK(rr, PIC_RESP_SLVERR)
      wr(8'h24, 32'h0000_0001);
      `CHK(br, PIC_RESP_SLVERR)
   endtask : t_reset
   task automatic t_pend();
      fire(16'h00A0);
      wr(PIC_OFF_ENABLE, 32'h0000_0020);
      quiet();
      rd(PIC_OFF_FLAGS);
      `CHK(rv, 32'h0000_00A0)
      wr(PIC_OFF_CTRL, 32'h0000_0001);
      wait_req({1'b1, 4'h5, 2'h0});
      wr(PIC_OFF_FLAGS, 32'hFFFF_FFDF);
      rd(PIC_OFF_FLAGS);
      `CHK(rv, 32'h0000_0080)
      quiet();
   endtask : t_pend
   task automatic t_prio();
      wr(PIC_OFF_FLAGS, 32'h0000_0000);
      s_axi_wstrb <= 4'hE;
      wr(PIC_OFF_PRIORITY, 32'h0208_0000);
      s_axi_wstrb <= 4'h1;
      wr(PIC_OFF_PRIORITY, 32'hFFFF_FF73);
      s_axi_wstrb <= 4'hF;
      rd(PIC_OFF_PRIORITY);
      `CHK(rv, 32'h0208_0073)
      wr(PIC_OFF_ENABLE, 32'h0000_1209);
      fire(16'h1208);
      wait_req({1'b1, 4'h9, 2'h2});
   endtask : t_prio
   task automatic t_nest();
      @(posedge aclk);
      ack_en <= 1'b1;
      quiet();
      fire(16'h0001);
      wait_req({1'b1, 4'h0, 2'h3});
      wr(PIC_OFF_FLAGS, 32'h0000_1008);
      ret();
      quiet();
      ret();
      wait_req({1'b1, 4'hC, 2'h2});
      wr(PIC_OFF_FLAGS, 32'h0000_0008);
      ret();
      wait_req({1'b1, 4'h3, 2'h1});
      wr(PIC_OFF_FLAGS, 32'h0000_0000);
      ret();
   endtask : t_nest
   task automatic t_ext_a();
      logic [1:0] e;
      wr(PIC_OFF_CTRL, 32'h0000_001A);
      pin_a(8'h04, 1'b0);
      // Code 3 included: it must detect nothing
      for (int i = 0; i < 4; i++) begin
         e = 2'(i);
         wr(PIC_OFF_CTRL, {24'h00_0000, e, 6'h1A});
         pin_a(8'h0C, e == PIC_EDGE_RISE || e == PIC_EDGE_BOTH);
         pin_a(8'h04, e == PIC_EDGE_FALL || e == PIC_EDGE_BOTH);
      end
   endtask : t_ext_a
   task automatic t_ext_b();
      wr(PIC_OFF_CTRL, 32'h0000_0205);
      wr(PIC_OFF_PIN_ENABLES, 32'h0000_0400);
      ext_irq_b_pins <= 16'h0400;
      wait_req({1'b1, PIC_SRC_EXT_B, 2'h3});
      rd(PIC_OFF_PIN_FLAGS);
      `CHK(rv, 32'h0000_0400)
      rd(PIC_OFF_FLAGS);
      `CHK(rv[2], 1'b1)
      wr(PIC_OFF_PIN_FLAGS, 32'h0000_0000);
      ret();
      ext_irq_b_pins <= 16'h0000;
      repeat (8) @(posedge aclk);
      rd(PIC_OFF_PIN_FLAGS);
      `CHK(rv, 32'h0000_0400)
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      `CHK(irq_req, 7'h00)
      @(posedge aclk);
      aresetn <= 1'b1;
      rd(PIC_OFF_STATUS);
      `CHK(rv, PIC_RST_WORD)
   endtask : t_ext_b
   task automatic end_sim();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////
   // Main sequence after four reset cycles
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_pend();
      t_prio();
      t_nest();
      t_ext_a();
      t_ext_b();
      end_sim();
   end
   // Watchdog well past the expected run length
   initial begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      end_sim();
   end
endmodule : tb
